// >>> hw/otpsr_cfg.svh
`ifndef OTPSR_CFG_SVH
`define OTPSR_CFG_SVH

// secure space layout (byte offsets within the secure space)
`define OTPSR_SPACE_BYTES    1024
`define OTPSR_ADDR_BITS      10
`define OTPSR_REGION_BYTES   32
`define OTPSR_REGION_COUNT   32
`define OTPSR_RAND_BYTES     16
`define OTPSR_LOCK_BASE      10'h010
`define OTPSR_LOCK_BYTES     4
`define OTPSR_RFU_BASE       10'h014
`define OTPSR_ERASED_BYTE    8'hff
`define OTPSR_UNDEF_BYTE     8'hff

// sector size of the main array, in address bits (256 KB)
`define OTPSR_SECTOR_BITS    18
`define OTPSR_HOST_ADDR_BITS 32

`endif

// >>> hw/otpsr_pkg.sv
package otpsr_pkg;

  typedef enum logic [2:0] {
    OTPSR_OP_ARRAY_READ,
    OTPSR_OP_ARRAY_PROGRAM,
    OTPSR_OP_ARRAY_ERASE,
    OTPSR_OP_OVERLAY_ENTRY,
    OTPSR_OP_OVERLAY_EXIT,
    OTPSR_OP_SPI_SECURE_READ,
    OTPSR_OP_SPI_SECURE_PROGRAM
  } otpsr_op_type;

endpackage

// >>> hw/otpsr_access.sv
// Behaviour
// - 1024-byte space, 32 lockable 32-byte regions.
// - random-number bytes refuse programming, flag error unless data is ff.
// - lock bytes hold one bit per region.
// - lock bit zero blocks its region permanently.
// - twelve reserved bytes remain host programmable.
// - other regions erased, accept host programming.
// - octal bus: cleared config bit blocks programming.
// - such blocked program is silent, no error.
// - octal entry overlays space onto given sector.
// - overlaid sector beyond space returns undefined.
// - other sectors read array while overlaid.
// - exit sequence removes the overlay.
// - array-style programming, repeatable, never erasable.
// - octal program ignores A10 and above.
// - sector protection scheme never affects programming.
// - spi uses dedicated secure read/program.
`timescale 1ns/1ps
`include "otpsr_cfg.svh"

module otpsr_access #(
  parameter int          SECTOR_BITS = `OTPSR_SECTOR_BITS,
  parameter logic [127:0] RAND_VALUE = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
  input  wire logic                                  clock,
  input  wire logic                                  rst,
  input  wire logic                                  bus_is_octal,
  input  wire logic                                  config_reg_one_secure_lock,
  input  wire logic                                  cmd_valid,
  input  wire otpsr_pkg::otpsr_op_type               cmd_op,
  input  wire logic [`OTPSR_HOST_ADDR_BITS-1:0]      cmd_addr,
  input  wire logic [7:0]                            cmd_wdata,
  input  wire logic                                  error_clear,
  input  wire logic                                  arr_rvalid,
  input  wire logic [7:0]                            arr_rdata,
  output logic                                       resp_valid,
  output logic [7:0]                                 resp_data,
  output logic                                       prog_done,
  output logic                                       program_error,
  output logic                                       overlay_active,
  output logic                                       arr_req_valid,
  output otpsr_pkg::otpsr_op_type                    arr_req_op,
  output logic [`OTPSR_HOST_ADDR_BITS-1:0]           arr_req_addr,
  output logic [7:0]                                 arr_req_wdata
);
  import otpsr_pkg::*;

  localparam int AW = `OTPSR_HOST_ADDR_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // storage: the secure space is nonvolatile and survives reset

  logic [7:0] otp_mem [0:`OTPSR_SPACE_BYTES-1];

  initial begin
    for (int i = 0; i < `OTPSR_SPACE_BYTES; i++) begin
      otp_mem[i] = `OTPSR_ERASED_BYTE;
    end
    for (int i = 0; i < `OTPSR_RAND_BYTES; i++) begin
      otp_mem[i] = RAND_VALUE[i*8 +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overlay state

  logic                  overlay_active_reg;
  logic [AW-1:0]         overlay_sector_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overlay_active_reg <= 1'b0;
      overlay_sector_reg <= '0;
    end else if (cmd_valid && bus_is_octal) begin
      if (cmd_op == OTPSR_OP_OVERLAY_ENTRY) begin
        overlay_active_reg <= 1'b1;
        overlay_sector_reg <= cmd_addr >> SECTOR_BITS;
      end else if (cmd_op == OTPSR_OP_OVERLAY_EXIT) begin
        overlay_active_reg <= 1'b0;
      end
    end
  end

  assign overlay_active = overlay_active_reg;

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  logic                         in_overlay;
  logic [SECTOR_BITS-1:0]       sect_off;
  logic                         off_in_space;
  logic [`OTPSR_ADDR_BITS-1:0]  otp_addr;
  logic                         is_otp_read;
  logic                         is_otp_prog;
  logic                         is_otp_erase;
  logic                         is_array;
  logic [4:0]                   region;
  logic [7:0]                   lock_byte;
  logic                         region_locked;
  logic                         in_rand;
  logic                         prog_blocked_silent;
  logic                         prog_refused;

  always_comb begin
    in_overlay   = overlay_active_reg && bus_is_octal &&
                   ((cmd_addr >> SECTOR_BITS) == overlay_sector_reg);
    sect_off     = cmd_addr[SECTOR_BITS-1:0];
    off_in_space = (sect_off >> `OTPSR_ADDR_BITS) == '0;
    // only A9..A0 survive; A10 and above wrap into the space
    otp_addr     = cmd_addr[`OTPSR_ADDR_BITS-1:0];
    is_otp_read  = 1'b0;
    is_otp_prog  = 1'b0;
    is_otp_erase = 1'b0;
    is_array     = 1'b0;
    if (cmd_valid) begin
      case (cmd_op)
        OTPSR_OP_ARRAY_READ: begin
          is_otp_read = in_overlay;
          is_array    = !in_overlay;
        end
        OTPSR_OP_ARRAY_PROGRAM: begin
          is_otp_prog = in_overlay;
          is_array    = !in_overlay;
        end
        OTPSR_OP_ARRAY_ERASE: begin
          is_otp_erase = in_overlay;
          is_array     = !in_overlay;
        end
        OTPSR_OP_SPI_SECURE_READ: begin
          is_otp_read = !bus_is_octal;
        end
        OTPSR_OP_SPI_SECURE_PROGRAM: begin
          is_otp_prog = !bus_is_octal;
        end
        default: begin
          is_array = 1'b0;
        end
      endcase
    end
    region        = otp_addr[`OTPSR_ADDR_BITS-1:5];
    lock_byte     = otp_mem[`OTPSR_LOCK_BASE + {7'h00, region[4:3]}];
    region_locked = !lock_byte[region[2:0]];
    in_rand       = otp_addr < `OTPSR_ADDR_BITS'(`OTPSR_RAND_BYTES);
    // sector protection mode plays no part in either gate below
    prog_blocked_silent = bus_is_octal && !config_reg_one_secure_lock;
    prog_refused  = in_rand || region_locked;
  end

  ////////////////////////////////////////////////////////////////////////////
  // secure programming: cells only ever go from one to zero

  always_ff @(posedge clock) begin
    if (is_otp_prog && !prog_blocked_silent && !prog_refused) begin
      otp_mem[otp_addr] <= otp_mem[otp_addr] & cmd_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prog_done <= 1'b0;
    end else begin
      // an erase of the overlaid sector completes with no effect
      prog_done <= is_otp_prog || is_otp_erase;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      program_error <= 1'b0;
    end else if (is_otp_prog && !prog_blocked_silent && prog_refused &&
                 (!in_rand || cmd_wdata != `OTPSR_ERASED_BYTE || region_locked)) begin
      program_error <= 1'b1;
    end else if (error_clear) begin
      program_error <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answers and array pass-through

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_data  <= 8'h00;
    end else if (is_otp_read) begin
      resp_valid <= 1'b1;
      if (!bus_is_octal || off_in_space) begin
        resp_data <= otp_mem[otp_addr];
      end else begin
        resp_data <= `OTPSR_UNDEF_BYTE;
      end
    end else if (arr_rvalid) begin
      resp_valid <= 1'b1;
      resp_data  <= arr_rdata;
    end else begin
      resp_valid <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arr_req_valid <= 1'b0;
      arr_req_op    <= OTPSR_OP_ARRAY_READ;
      arr_req_addr  <= '0;
      arr_req_wdata <= 8'h00;
    end else begin
      arr_req_valid <= is_array;
      if (is_array) begin
        arr_req_op    <= cmd_op;
        arr_req_addr  <= cmd_addr;
        arr_req_wdata <= cmd_wdata;
      end
    end
  end

endmodule

// >>> testbench/otpsr_array_model.sv
`timescale 1ns/1ps
module otpsr_array_model
  import otpsr_pkg::*;
#(parameter int DELAY = 3) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 arr_req_valid,
  input  wire otpsr_pkg::otpsr_op_type arr_req_op,
  input  wire logic [31:0]          arr_req_addr,
  output logic                      arr_rvalid,
  output logic [7:0]                arr_rdata
);
  logic [7:0] last_reg;
  int         cnt_reg;
  // array content is addr xor 5a; data flips every idle cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 0;
      arr_rvalid <= 1'b0;
      arr_rdata <= 8'h00;
      last_reg <= 8'h00;
    end else begin
      arr_rvalid <= 1'b0;
      arr_rdata <= ~arr_rdata;
      if (arr_req_valid && arr_req_op == OTPSR_OP_ARRAY_READ) begin
        cnt_reg <= DELAY;
        last_reg <= arr_req_addr[7:0] ^ 8'h5a;
      end else if (cnt_reg > 0) begin
        cnt_reg <= cnt_reg - 1;
        if (cnt_reg == 1) begin
          arr_rvalid <= 1'b1;
          arr_rdata <= last_reg;
        end
      end
    end
  end
endmodule

// >>> testbench/otpsr_access_asserts.sv
`timescale 1ns/1ps
module otpsr_checker
  import otpsr_pkg::*;
(
  input wire logic clock, rst, bus_is_octal, config_reg_one_secure_lock, cmd_valid,
  input wire otpsr_pkg::otpsr_op_type cmd_op, arr_req_op,
  input wire logic error_clear, resp_valid, prog_done, program_error,
  input wire logic overlay_active, arr_req_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_oct(otpsr_op_type op); cmd_valid && bus_is_octal && cmd_op == op; endsequence
  sequence s_spi(otpsr_op_type op); cmd_valid && !bus_is_octal && cmd_op == op; endsequence
  a_entry_sets_overlay: assert property (s_oct(OTPSR_OP_OVERLAY_ENTRY) |=> overlay_active)
    else $error("overlay not on after entry");
  a_exit_clears_overlay: assert property (s_oct(OTPSR_OP_OVERLAY_EXIT) |=> !overlay_active)
    else $error("overlay still on after exit");
  a_spi_no_entry: assert property (s_spi(OTPSR_OP_OVERLAY_ENTRY) && !overlay_active
    |=> !overlay_active) else $error("overlay entered on spi");
  a_spi_read_ans: assert property (s_spi(OTPSR_OP_SPI_SECURE_READ) |=> resp_valid)
    else $error("spi secure read unanswered");
  a_spi_prog_done: assert property (s_spi(OTPSR_OP_SPI_SECURE_PROGRAM) |=> prog_done)
    else $error("spi secure program not done");
  a_lock_silent: assert property (s_oct(OTPSR_OP_ARRAY_PROGRAM) && !config_reg_one_secure_lock
    && !program_error |=> !program_error) else $error("blocked program flagged error");
  a_error_sticky: assert property (program_error && !error_clear |=> program_error)
    else $error("program error dropped");
  a_error_clears: assert property (error_clear && !cmd_valid |=> !program_error)
    else $error("program error not cleared");
  a_plain_array_read: assert property (cmd_valid && cmd_op == OTPSR_OP_ARRAY_READ
    && !overlay_active |=> arr_req_valid && arr_req_op == OTPSR_OP_ARRAY_READ)
    else $error("array read not forwarded");
  a_reset_quiet: assert property (disable iff (1'b0) rst |-> !overlay_active && !program_error)
    else $error("state not cleared in reset");
endmodule
bind otpsr_access otpsr_checker i_chk(.clock, .rst, .bus_is_octal, .config_reg_one_secure_lock,
  .cmd_valid, .cmd_op, .arr_req_op, .error_clear, .resp_valid, .prog_done, .program_error,
  .overlay_active, .arr_req_valid);

// >>> testbench/tb_otpsr_access.sv
`timescale 1ns/1ps
module tb_otpsr_access;
  import otpsr_pkg::*;
  localparam logic [127:0] RV  = 128'h1122_3344_5566_7788_99aa_bbcc_ddee_ff00;
  localparam logic [31:0]  SEC = 32'h0004_0000;
  // reset starts low so the rise below is an edge the async reset sees
  logic clock = 0, rst = 0, bus_is_octal = 1, config_reg_one_secure_lock = 1;
  logic cmd_valid = 0, error_clear = 0, arr_rvalid, resp_valid, prog_done, program_error;
  logic overlay_active, arr_req_valid;
  logic [31:0] cmd_addr = 0, arr_req_addr;
  logic [7:0] cmd_wdata = 0, arr_rdata, resp_data, arr_req_wdata;
  otpsr_op_type cmd_op = OTPSR_OP_ARRAY_READ, arr_req_op;
  int n_errors = 0, compares = 0;
  always #2.5 clock = ~clock;
  otpsr_access #(.RAND_VALUE(RV)) i_dut(.clock, .rst, .bus_is_octal, .config_reg_one_secure_lock,
    .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .error_clear, .arr_rvalid, .arr_rdata,
    .resp_valid, .resp_data, .prog_done, .program_error, .overlay_active, .arr_req_valid,
    .arr_req_op, .arr_req_addr, .arr_req_wdata);
  otpsr_array_model i_arr(.clock, .rst, .arr_req_valid, .arr_req_op, .arr_req_addr,
    .arr_rvalid, .arr_rdata);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input otpsr_op_type op, input logic [31:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    cmd_valid = 1; cmd_op = op; cmd_addr = a; cmd_wdata = d;
    @(posedge clock) #1;
    cmd_valid = 0;
  endtask
  task automatic rd(input otpsr_op_type op, input logic [31:0] a, input logic [7:0] e);
    cmd(op, a, 8'h00);
    for (int i = 0; i < 20 && resp_valid !== 1'b1; i++) @(posedge clock) #1;
    chk(resp_data, e);
  endtask
  // program at c0, result visible at c1, then error flag cleared
  task automatic pg(input logic [31:0] a, input logic [7:0] d, input logic err);
    cmd(OTPSR_OP_ARRAY_PROGRAM, a, d);
    chk({7'h0, prog_done}, 8'h01);
    chk({7'h0, program_error}, {7'h0, err});
    error_clear = 1;
    @(posedge clock) #1;
    error_clear = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_layout();
    cmd(OTPSR_OP_OVERLAY_ENTRY, SEC + 32'h123, 8'h00);
    chk({7'h0, overlay_active}, 8'h01);
    for (int i = 0; i < 32; i++) rd(OTPSR_OP_ARRAY_READ, SEC + i, i < 16 ? RV[8*i+:8] : 8'hff);
    rd(OTPSR_OP_ARRAY_READ, SEC + 32'h3ff, 8'hff);
  endtask
  task automatic t_program();
    pg(SEC, 8'h00, 1'b1);
    rd(OTPSR_OP_ARRAY_READ, SEC, RV[7:0]);
    pg(SEC + 32'h20, 8'h3c, 1'b0);
    pg(SEC + 32'h20, 8'hf0, 1'b0);
    pg(SEC + 32'h420, 8'h11, 1'b0);
    rd(OTPSR_OP_ARRAY_READ, SEC + 32'h20, 8'h10);
    pg(SEC + 32'h14, 8'h0f, 1'b0);
    rd(OTPSR_OP_ARRAY_READ, SEC + 32'h14, 8'h0f);
    cmd(OTPSR_OP_ARRAY_ERASE, SEC, 8'h00);
    rd(OTPSR_OP_ARRAY_READ, SEC + 32'h20, 8'h10);
  endtask
  task automatic t_lock();
    pg(SEC + 32'h10, 8'hfd, 1'b0);
    pg(SEC + 32'h22, 8'h00, 1'b1);
    rd(OTPSR_OP_ARRAY_READ, SEC + 32'h22, 8'hff);
    pg(SEC + 32'h12, 8'hfe, 1'b0);
    pg(SEC + 32'h200, 8'h00, 1'b1);
    config_reg_one_secure_lock = 0;
    pg(SEC + 32'h60, 8'h00, 1'b0);
    rd(OTPSR_OP_ARRAY_READ, SEC + 32'h60, 8'hff);
    config_reg_one_secure_lock = 1;
  endtask
  task automatic t_array();
    rd(OTPSR_OP_ARRAY_READ, 32'h0000_0100, 8'h5a);
    cmd(OTPSR_OP_ARRAY_PROGRAM, 32'h0000_0102, 8'ha5);
    chk(arr_req_wdata, 8'ha5);
    chk(arr_req_addr[7:0], 8'h02);
    chk({5'h0, arr_req_op}, {5'h0, OTPSR_OP_ARRAY_PROGRAM});
    cmd(OTPSR_OP_OVERLAY_EXIT, SEC, 8'h00);
    chk({7'h0, overlay_active}, 8'h00);
    rd(OTPSR_OP_ARRAY_READ, SEC + 32'h20, 8'h7a);
    cmd(OTPSR_OP_OVERLAY_ENTRY, SEC, 8'h00);
    @(posedge clock) #1 rst = 1;
    @(posedge clock) #1 rst = 0;
    chk({7'h0, overlay_active}, 8'h00);
  endtask
  task automatic t_spi();
    bus_is_octal = 0;
    cmd(OTPSR_OP_SPI_SECURE_PROGRAM, 32'h44, 8'h81);
    chk({7'h0, prog_done}, 8'h01);
    rd(OTPSR_OP_SPI_SECURE_READ, 32'h44, 8'h81);
    cmd(OTPSR_OP_OVERLAY_ENTRY, SEC, 8'h00);
    chk({7'h0, overlay_active}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1 rst = 1;
    repeat (2) @(posedge clock);
    #1 rst = 0;
    chk({6'h0, overlay_active, program_error}, 8'h00);
    t_layout();
    t_program();
    t_lock();
    t_array();
    t_spi();
    stop_test();
  end
  initial begin
    #50us;
    n_errors++;
    stop_test();
  end
endmodule
